// File: src/iwsfe_defines.svh
// constants for the i2c write-only slave front end
// assumes inclusion by the package, the slave design and the bench
`ifndef IWSFE_DEFINES_SVH
`define IWSFE_DEFINES_SVH

// fixed five upper address bits (arbitrary default)
`define IWSFE_ADDR_HI       5'h0E
`define IWSFE_OP_MARGIN     3'h1
`define IWSFE_OP_WATCHDOG   3'h3
`define IWSFE_OP_MSB        7
`define IWSFE_OP_LSB        5
`define IWSFE_VAL_MSB       4
`define IWSFE_FIFO_DEPTH    16
`define IWSFE_FIFO_AW       4
`define IWSFE_BYTE_W        8
// clocks after reset release during which straps load; the last load takes the synchronised pin levels
`define IWSFE_STRAP_SETTLE  2'h3

`endif

// File: src/iwsfe_pkg.sv
// types for the i2c write-only slave front end
// assumes iwsfe_defines.svh is on the include path
`include "iwsfe_defines.svh"

package iwsfe_pkg;

  typedef logic [`IWSFE_BYTE_W-1:0] iwsfe_byte_type;

  typedef enum logic [2:0] {
    IWSFE_IDLE  = 3'h0,
    IWSFE_ADDR  = 3'h1,
    IWSFE_AACK  = 3'h3,
    IWSFE_DATA  = 3'h2,
    IWSFE_DACK  = 3'h6,
    IWSFE_SKIP  = 3'h7
  } iwsfe_state_type;

endpackage

// File: src/iwsfe_stream_if.sv
// valid/ready byte stream between the slave core and its fifo
// assumes a single clock shared by both ends
`timescale 1ns/10ps
`default_nettype none

interface iwsfe_stream_if;
  import iwsfe_pkg::*;
  logic           valid;
  logic           ready;
  iwsfe_byte_type data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// File: src/iwsfe_fifo.sv
// parameterised fifo with valid/ready on both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/10ps
`default_nettype none

module iwsfe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic             doWr;
  logic             doRd;
  logic             empty;

  // the output register holds a word too, so it counts toward the depth
  assign inReady  = (wrPtr - rdPtr + {{AW{1'b0}}, outValid}) != (AW+1)'(DEPTH);
  assign empty    = wrPtr == rdPtr;
  assign doWr     = inValid && inReady;
  // read data comes from a register, so valid is set on the same load that steps the pointer
  assign doRd     = !empty && (!outValid || outReady);

  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr <= '0;
    end else if (doWr) begin
      wrPtr <= wrPtr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdPtr    <= '0;
      outValid <= 1'b0;
      outData  <= '0;
    end else begin
      if (doRd) begin
        rdPtr    <= rdPtr + 1'b1;
        outData  <= mem[rdPtr[AW-1:0]];
        outValid <= 1'b1;
      end else if (outReady) begin
        outValid <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// File: src/iwsfe_slave.sv
// write-only i2c slave front end: address match, acks, command bytes
// assumes scl/sda and straps are asynchronous pins sampled by clk
//
// Functional notes
// RQ1: master opens with start, then seven address bits and direction bit.
// RQ2: master always sends direction bit zero; device only receives.
// RQ3: on address match with write direction, device drives acknowledge low.
// RQ4: address bit1 from clock-select strap, bit0 from address strap.
// RQ5: clock-select strap high makes sync pin an oscillator output.
// RQ6: clock-select strap low makes sync pin an external clock input.
// RQ7: upper five address bits fixed, four devices share a bus.
// RQ8: after address acknowledge, every received data byte is acknowledged.
// RQ9: byte splits into 3-bit operation field and 5-bit value field.
// RQ10: master sends an all-zero-value first command before each operation.
// RQ11: stop returns slave to idle awaiting the next start.
// RQ12: on address mismatch, sda stays released until next start.
`include "iwsfe_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module iwsfe_slave
  import iwsfe_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // i2c pins (open drain: out is always low, oe pulls)
  input  wire logic                sclIn,
  input  wire logic                sdaIn,
  output logic                     sdaOut,
  output logic                     sdaOe,
  // straps
  input  wire logic                clockSelectStrap,
  input  wire logic                addrStrap,
  // oscillator sync pin
  input  wire logic                oscClk,
  input  wire logic                oscSyncIn,
  output logic                     oscillatorSyncPinOut,
  output logic                     oscillatorSyncPinOe,
  output logic                     extSyncClk,
  // command byte stream
  output logic                     cmdValid,
  input  wire logic                cmdReady,
  output logic [2:0]               cmdOp,
  output logic [4:0]               cmdValue,
  output logic                     cmdFirst,
  // status
  output logic                     busy,
  output logic                     overflow
);
  iwsfe_stream_if  strm ();
  iwsfe_state_type state;
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic [1:0] selSync;
  logic [1:0] adrSync;
  logic [1:0] oscSync;
  logic       sclPrev;
  logic       sdaPrev;
  logic [1:0] strapWait;
  logic [1:0] strapBits;
  logic [6:0] ownAddr;
  logic [7:0] shiftReg;
  logic [3:0] bitCnt;
  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic       pushed;
  logic       rxPhase;
  logic       byteDone;
  logic       addrMatch;

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; only the second stage is read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      selSync <= 2'h3;
      adrSync <= 2'h3;
      oscSync <= 2'h0;
    end else begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      selSync <= {selSync[0], clockSelectStrap};
      adrSync <= {adrSync[0], addrStrap};
      oscSync <= {oscSync[0], oscSyncIn};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
    end
  end

  assign sclRise   = sclSync[1] && !sclPrev;
  assign sclFall   = !sclSync[1] && sclPrev;
  // sda moving while scl high marks start or stop
  assign startSeen = sclSync[1] && sclPrev && sdaPrev && !sdaSync[1];
  assign stopSeen  = sclSync[1] && sclPrev && !sdaPrev && sdaSync[1];

  ////////////////////////////////////////////////////////////////////////
  // straps caught once the synchronisers hold pin levels, not their reset fill;
  // open pins read high via pullup
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strapWait <= 2'h0;
      strapBits <= 2'h3;
    end else if (strapWait != `IWSFE_STRAP_SETTLE) begin
      strapWait <= strapWait + 2'h1;
      strapBits <= {selSync[1], adrSync[1]};   // [RQ4]
    end
  end

  assign ownAddr = {`IWSFE_ADDR_HI, strapBits};   // [RQ7] [RQ4]
  assign busy    = state != IWSFE_IDLE;

  // sync pin direction follows the clock-select strap
  assign oscillatorSyncPinOe  = strapBits[1];          // [RQ5] [RQ6]
  assign oscillatorSyncPinOut = strapBits[1] ? oscClk : 1'b0;   // [RQ5]
  assign extSyncClk           = strapBits[1] ? 1'b0 : oscSync[1];   // [RQ6]

  ////////////////////////////////////////////////////////////////////////
  // frame decode shared by the state, counter and shift concerns
  assign rxPhase   = (state == IWSFE_ADDR) || (state == IWSFE_DATA);
  // eighth bit is in once scl falls after the eighth rise
  assign byteDone  = rxPhase && sclFall && (bitCnt == 4'h8);
  // write direction only: a read request never matches
  assign addrMatch = shiftReg == {ownAddr, 1'b0};   // [RQ3] [RQ2]

  ////////////////////////////////////////////////////////////////////////
  // frame state; start and stop win over everything else
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= IWSFE_IDLE;
    end else if (startSeen) begin
      // repeated start also restarts address collection [RQ1]
      state <= IWSFE_ADDR;
    end else if (stopSeen) begin
      state <= IWSFE_IDLE;   // [RQ11]
    end else begin
      case (state)
        IWSFE_ADDR: begin
          if (byteDone && addrMatch) begin
            state <= IWSFE_AACK;   // [RQ3]
          end else if (byteDone) begin
            state <= IWSFE_SKIP;   // [RQ12]
          end
        end
        IWSFE_DATA: begin
          if (byteDone) begin
            state <= IWSFE_DACK;   // [RQ8]
          end
        end
        IWSFE_AACK, IWSFE_DACK: begin
          // release sda at the end of the ninth clock
          if (sclFall) begin
            state <= IWSFE_DATA;
          end
        end
        IWSFE_SKIP: begin
          state <= IWSFE_SKIP;   // [RQ12]
        end
        IWSFE_IDLE: begin
          state <= IWSFE_IDLE;
        end
        default: begin
          state <= IWSFE_IDLE;
        end
      endcase
    end
  end

  // bit counter: cleared by start and at every byte boundary
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bitCnt <= 4'h0;
    end else if (startSeen || byteDone) begin
      bitCnt <= 4'h0;
    end else if (rxPhase && sclRise) begin
      bitCnt <= bitCnt + 4'h1;
    end
  end

  // msb first: each rising scl in an address or data byte shifts in one bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shiftReg <= 8'h00;
    end else if (rxPhase && sclRise) begin
      shiftReg <= {shiftReg[6:0], sdaSync[1]};
    end
  end

  // open drain ack: only pulls low, never drives high
  assign sdaOut = 1'b0;
  assign sdaOe  = (state == IWSFE_AACK) || (state == IWSFE_DACK);   // [RQ3] [RQ8]

  ////////////////////////////////////////////////////////////////////////
  // received bytes enter the fifo when the ack phase opens
  assign pushed      = (state == IWSFE_DATA) && sclFall && bitCnt == 4'h8
                       && !startSeen && !stopSeen;
  assign strm.valid  = pushed;
  assign strm.data   = shiftReg;

  // a full fifo drops the byte but still acks; the loss is flagged sticky
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overflow <= 1'b0;
    end else if (pushed && !strm.ready) begin
      overflow <= 1'b1;
    end
  end

  iwsfe_byte_type fifoData;

  iwsfe_fifo #(
    .WIDTH (`IWSFE_BYTE_W),
    .DEPTH (`IWSFE_FIFO_DEPTH),
    .AW    (`IWSFE_FIFO_AW)
  ) u_fifo (
    .clk      (clk),
    .rst_b    (rst_b),
    .inValid  (strm.valid),
    .inReady  (strm.ready),
    .inData   (strm.data),
    .outValid (cmdValid),
    .outReady (cmdReady),
    .outData  (fifoData)
  );

  // command byte fields
  assign cmdOp    = fifoData[`IWSFE_OP_MSB:`IWSFE_OP_LSB];   // [RQ9]
  assign cmdValue = fifoData[`IWSFE_VAL_MSB:0];   // [RQ9]
  // flags a first command so the consumer can arm the operation
  assign cmdFirst = cmdValue == 5'h00
                    && (cmdOp == `IWSFE_OP_MARGIN || cmdOp == `IWSFE_OP_WATCHDOG);   // [RQ10]
endmodule

`default_nettype wire

// File: verif/iwsfe_slave_sva.sv
// checker for the slave front end top ports
// assumes bind onto iwsfe_slave, single clk domain
`timescale 1ns/10ps
`default_nettype none

module iwsfe_slave_sva (
  // watched ports
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       sclIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       clockSelectStrap,
  input wire logic       oscillatorSyncPinOe,
  input wire logic       extSyncClk,
  input wire logic       cmdValid,
  input wire logic       cmdReady,
  input wire logic [2:0] cmdOp,
  input wire logic [4:0] cmdValue,
  input wire logic       cmdFirst,
  input wire logic       busy
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  property p_ackRel;
    sdaOe && $fell(sclIn) |-> ##[1:5] !sdaOe;
  endproperty
  a_ackRel: assert property (p_ackRel) else $error("ack held past scl fall");
  property p_ackLow;
    $rose(sdaOe) |-> !sclIn ##0 sdaOe [*5];
  endproperty
  a_ackLow: assert property (p_ackLow) else $error("ack not in scl low");
  property p_drive;
    sdaOe |-> !sdaOut;
  endproperty
  a_drive: assert property (p_drive) else $error("sda driven high");
  property p_osc;
    $rose(busy) |-> oscillatorSyncPinOe == clockSelectStrap;
  endproperty
  a_osc: assert property (p_osc) else $error("sync pin direction");
  property p_ext;
    oscillatorSyncPinOe |-> !extSyncClk;
  endproperty
  a_ext: assert property (p_ext) else $error("ext clock while output");
  property p_hold;
    cmdValid && !cmdReady |=> cmdValid && $stable({cmdOp, cmdValue});
  endproperty
  a_hold: assert property (p_hold) else $error("command dropped");
  property p_first;
    cmdValid |-> cmdFirst == (cmdValue == 5'h00 && (cmdOp == 3'h1 || cmdOp == 3'h3));
  endproperty
  a_first: assert property (p_first) else $error("first flag");
  property p_idle;
    !busy |-> !sdaOe;
  endproperty
  a_idle: assert property (p_idle) else $error("ack while idle");
endmodule

bind iwsfe_slave iwsfe_slave_sva u_sva (
  .clk                 (clk),
  .rst_b               (rst_b),
  .sclIn               (sclIn),
  .sdaOut              (sdaOut),
  .sdaOe               (sdaOe),
  .clockSelectStrap    (clockSelectStrap),
  .oscillatorSyncPinOe (oscillatorSyncPinOe),
  .extSyncClk          (extSyncClk),
  .cmdValid            (cmdValid),
  .cmdReady            (cmdReady),
  .cmdOp               (cmdOp),
  .cmdValue            (cmdValue),
  .cmdFirst            (cmdFirst),
  .busy                (busy)
);

`default_nettype wire

// File: verif/iwsfe_i2c_master.sv
// bus master model: start, stop, bytes msb first
// assumes sda pulled up outside, 10 clk per half bit
`timescale 1ns/10ps
`default_nettype none

module iwsfe_i2c_master (
  // bus
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic half();
    repeat (10) @(posedge clk);
  endtask
  // sda falls with scl high
  task automatic start();
    sdaLow <= 1'b1;
    half();
    scl <= 1'b0;
  endtask
  // data moves mid-low so it never looks like start or stop
  task automatic bitx(input logic b, output logic s);
    repeat (3) @(posedge clk);
    sdaLow <= ~b;
    repeat (7) @(posedge clk);
    scl <= 1'b1;
    half();
    s = sda;
    scl <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(d[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask
  // repeated start: release sda in the low phase, raise scl, then start
  task automatic rstart();
    repeat (3) @(posedge clk);
    sdaLow <= 1'b0;
    repeat (7) @(posedge clk);
    scl <= 1'b1;
    half();
    start();
  endtask
  // only the master ends a frame
  task automatic stop();
    repeat (3) @(posedge clk);
    sdaLow <= 1'b1;
    repeat (7) @(posedge clk);
    scl <= 1'b1;
    half();
    sdaLow <= 1'b0;
    half();
  endtask
endmodule

`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the slave front end
// assumes master model drives the bus, bench drains the stream
`include "iwsfe_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic       clk, rst_b, clockSelectStrap, addrStrap, cmdReady, scl, sdaLow, ack;
  logic       sdaOut, sdaOe, oscillatorSyncPinOut, oscillatorSyncPinOe, extSyncClk;
  logic       cmdValid, cmdFirst, busy, overflow;
  logic       oscClk, oscSyncIn;
  logic [2:0] cmdOp;
  logic [4:0] cmdValue;
  int         fails, samples_checked;
  // wired-and bus: pull-up unless the master or the enabled device pulls low
  wire        sda = ~sdaLow & (sdaOe ? sdaOut : 1'b1);
  iwsfe_slave dut (
    .clk                  (clk),
    .rst_b                (rst_b),
    .sclIn                (scl),
    .sdaIn                (sda),
    .sdaOut               (sdaOut),
    .sdaOe                (sdaOe),
    .clockSelectStrap     (clockSelectStrap),
    .addrStrap            (addrStrap),
    .oscClk               (oscClk),
    .oscSyncIn            (oscSyncIn),
    .oscillatorSyncPinOut (oscillatorSyncPinOut),
    .oscillatorSyncPinOe  (oscillatorSyncPinOe),
    .extSyncClk           (extSyncClk),
    .cmdValid             (cmdValid),
    .cmdReady             (cmdReady),
    .cmdOp                (cmdOp),
    .cmdValue             (cmdValue),
    .cmdFirst             (cmdFirst),
    .busy                 (busy),
    .overflow             (overflow)
  );
  iwsfe_i2c_master u_mst (
    .clk    (clk),
    .sda    (sda),
    .scl    (scl),
    .sdaLow (sdaLow)
  );
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic rst(input logic cs, input logic ad);
    clockSelectStrap <= cs;
    addrStrap <= ad;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
  task automatic pop(input logic [7:0] e);
    @(negedge clk);
    repeat (40) if (cmdValid !== 1'b1) @(negedge clk);
    chk({cmdOp, cmdValue}, e);
    chk(cmdFirst, e[4:0] == 0 && (e[7:5] == 3'h1 || e[7:5] == 3'h3));
    @(posedge clk);
    cmdReady <= 1'b1;
    @(posedge clk);
    cmdReady <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_write(input logic cs, input logic ad, input logic [7:0] b1, b2);
    rst(cs, ad);
    // raise both sync sources so the pin direction shows in the levels
    oscClk    <= 1'b1;
    oscSyncIn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(oscillatorSyncPinOe, cs);
    chk(oscillatorSyncPinOut, cs);
    chk(extSyncClk, !cs);
    chk(extSyncClk & cs, 1'b0);
    oscClk    <= 1'b0;
    oscSyncIn <= 1'b0;
    u_mst.start();
    u_mst.xfer({`IWSFE_ADDR_HI, cs, ad, 1'b0}, ack);
    chk(ack, 1'b1);
    u_mst.xfer(b1, ack);
    chk(ack, 1'b1);
    u_mst.xfer(b2, ack);
    chk(ack, 1'b1);
    u_mst.stop();
    chk(busy, 1'b0);
    pop(b1);
    pop(b2);
  endtask
  task automatic t_mismatch();
    u_mst.start();
    u_mst.xfer({`IWSFE_ADDR_HI, 2'b00, 1'b0}, ack);
    chk(ack, 1'b0);
    u_mst.xfer(8'h20, ack);
    chk(ack, 1'b0);
    u_mst.rstart();
    u_mst.xfer({`IWSFE_ADDR_HI, 2'b11, 1'b0}, ack);
    chk(ack, 1'b1);
    u_mst.stop();
    u_mst.start();
    u_mst.xfer({`IWSFE_ADDR_HI, 2'b11, 1'b1}, ack);
    chk(ack, 1'b0);
    u_mst.stop();
    @(negedge clk);
    chk(cmdValid, 1'b0);
  endtask
  // consumer stalls so the queue overruns by one
  task automatic t_fill();
    u_mst.start();
    u_mst.xfer({`IWSFE_ADDR_HI, 2'b11, 1'b0}, ack);
    for (int i = 0; i < 17; i++) begin
      u_mst.xfer(8'(8'h60 + i), ack);
      chk(ack, 1'b1);
    end
    u_mst.stop();
    chk(overflow, 1'b1);
    for (int i = 0; i < 16; i++) pop(8'(8'h60 + i));
    @(negedge clk);
    chk(cmdValid, 1'b0);
  endtask
  initial begin
    rst_b = 1'b0;
    clockSelectStrap = 1'b0;
    addrStrap = 1'b0;
    cmdReady = 1'b0;
    oscClk = 1'b0;
    oscSyncIn = 1'b0;
    t_write(1'b0, 1'b0, 8'h20, 8'h25);
    t_write(1'b0, 1'b1, 8'h60, 8'h6B);
    t_write(1'b1, 1'b0, 8'h20, 8'hFC);
    t_write(1'b1, 1'b1, 8'h60, 8'h60);
    t_mismatch();
    t_fill();
    print_verdict();
  end
  initial begin
    #160000;
    fails++;
    print_verdict();
  end
endmodule

`default_nettype wire
